// ==== core/ocd_chan_div.sv ====
`timescale 1ns/1ps
// Channel divider with initial phase applied at each sync
module ocd_chan_div (
  input wire logic clk,
  input wire logic rst,
  ocd_div_if.div dif
);
  logic [9:0] div_q;
  logic [9:0] cnt_q;
  logic [4:0] wait_q;
  logic run_q;
  logic out_q;
  logic half_q;
  logic [10:0] hi_len;

  // High time of one output period, about half of it
  assign hi_len = ({1'b0, div_q} + 11'h001) >> 1;

  // Shadow load, phase wait and count
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_q <= 10'h000;
      cnt_q <= 10'h000;
      wait_q <= 5'h00;
      run_q <= 1'b1;
      half_q <= 1'b0;
    end else if (dif.ce) begin
      if (dif.sync) begin
        div_q <= dif.div_val;
        cnt_q <= 10'h000;
        wait_q <= dif.phase[5:1];
        half_q <= dif.phase[0];
        run_q <= (dif.phase[5:1] == 5'h00);
      end else if (!run_q) begin
        wait_q <= wait_q - 5'h01;
        run_q <= (wait_q == 5'h01);
      end else begin
        cnt_q <= (cnt_q == div_q) ? 10'h000 : cnt_q + 10'h001;
      end
    end
  end

  // Output level, held low while waiting out the phase
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      out_q <= 1'b0;
    end else if (dif.ce) begin
      if (dif.sync || !run_q) begin
        out_q <= 1'b0;
      end else begin
        out_q <= (div_q == 10'h000) || ({1'b0, cnt_q} < hi_len);
      end
    end
  end

  assign dif.out_true = out_q;
  assign dif.half_step = half_q;
  assign dif.running = run_q;
endmodule

// ==== core/ocd_pin_drv.sv ====
`timescale 1ns/1ps
// Maps driver mode to plus and minus pin levels and enables
module ocd_pin_drv (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [3:0] mode,
  input wire logic src,
  output logic plus_o,
  output logic plus_oe,
  output logic minus_o,
  output logic minus_oe
);
  import ocd_pkg::*;
  logic p_d;
  logic pe_d;
  logic m_d;
  logic me_d;

  // Mode decode
  always_comb begin
    p_d = 1'b0;
    pe_d = 1'b0;
    m_d = 1'b0;
    me_d = 1'b0;
    case (mode)
      DRV_INPH_T: begin
        p_d = src;
        m_d = src;
        pe_d = 1'b1;
        me_d = 1'b1;
      end
      DRV_OPP_T: begin
        p_d = src;
        m_d = !src;
        pe_d = 1'b1;
        me_d = 1'b1;
      end
      DRV_INPH_C: begin
        p_d = !src;
        m_d = !src;
        pe_d = 1'b1;
        me_d = 1'b1;
      end
      DRV_OPP_C: begin
        p_d = !src;
        m_d = src;
        pe_d = 1'b1;
        me_d = 1'b1;
      end
      DRV_P_T: begin
        p_d = src;
        pe_d = 1'b1;
      end
      DRV_M_T: begin
        m_d = src;
        me_d = 1'b1;
      end
      DRV_P_C: begin
        p_d = !src;
        pe_d = 1'b1;
      end
      DRV_M_C: begin
        m_d = !src;
        me_d = 1'b1;
      end
      // Both released: high-Z and tristate codes
      default: begin
        pe_d = 1'b0;
        me_d = 1'b0;
      end
    endcase
  end

  // Registered pins
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      plus_o <= 1'b0;
      plus_oe <= 1'b0;
      minus_o <= 1'b0;
      minus_oe <= 1'b0;
    end else if (ce) begin
      plus_o <= p_d;
      plus_oe <= pe_d;
      minus_o <= m_d;
      minus_oe <= me_d;
    end
  end
endmodule

// ==== core/ocd_top.sv ====
// Register access over APB was decided locally.
`timescale 1ns/1ps
// What this block does
// - Mode 0111: plus true, minus complement
// - Mode 1011: both pins complement, in phase
// - Mode 1100: plus complement, minus true
// - Single pin, high-Z and tristate codes
// - Channel divides by value plus one
// - Divider value from two registers
// - Initial phase in half periods
// - Source select bits for channels 4-6
// - Bit 4 weak or strong drive
// - Cleanup divider codes zero or one-hot
module ocd_top (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ocd_pkg::PADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sync_n,
  output logic out_plus,
  output logic out_plus_oe,
  output logic out_minus,
  output logic out_minus_oe,
  output logic half_step,
  output logic cleanup_loop_clock_output,
  output logic cleanup_loop_weak_drive,
  output logic [2:0] channel_source_select
);
  import ocd_pkg::*;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] mode_q;
  logic [7:0] div_lo_q;
  logic [7:0] ph_hi_q;
  logic [7:0] clo_q;
  logic [2:0] sync_q;
  logic sync_ev;
  logic [3:0] cl_cnt_q;
  logic cl_d;
  logic wr_ok;
  logic hit;
  logic [7:0] rd_d;

  ocd_div_if dif ();

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------

  // Address decode
  always_comb begin
    hit = 1'b1;
    rd_d = 8'h00;
    case (paddr)
      ADDR_MODE: rd_d = mode_q;
      ADDR_DIV_LO: rd_d = div_lo_q;
      ADDR_PH_HI: rd_d = ph_hi_q;
      ADDR_CLO: rd_d = clo_q;
      ADDR_STAT: rd_d = {5'h00, dif.half_step, dif.running, dif.out_true};
      default: hit = 1'b0;
    endcase
  end

  // Write commits at the completing access edge
  assign wr_ok = psel && penable && pready && pwrite && hit;

  // Zero wait state answer, data and error registered
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (ce) begin
      pready <= psel && !penable && !pready;
      pslverr <= psel && !penable && !pready && !hit;
      if (psel && !penable && !pwrite) begin
        prdata <= {24'h00_0000, rd_d};
      end
    end
  end

  // Register writes; status register is read only
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_q <= RST_MODE;
      div_lo_q <= RST_DIV_LO;
      ph_hi_q <= RST_PH_HI;
      clo_q <= RST_CLO;
    end else if (ce && wr_ok) begin
      case (paddr)
        ADDR_MODE: mode_q <= pwdata[7:0];
        ADDR_DIV_LO: div_lo_q <= pwdata[7:0];
        ADDR_PH_HI: ph_hi_q <= pwdata[7:0];
        ADDR_CLO: clo_q <= pwdata[7:0];
        default: mode_q <= mode_q;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Sync input
  // ----------------------------------------------------------------

  // Two stage synchroniser, third stage for falling edge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync_q <= 3'b111;
    end else if (ce) begin
      sync_q <= {sync_q[1:0], sync_n};
    end
  end

  assign sync_ev = !sync_q[1] && sync_q[2];

  // ----------------------------------------------------------------
  // Channel divider and pin driver
  // ----------------------------------------------------------------

  assign dif.div_val = {ph_hi_q[DIVHI_LSB +: 2], div_lo_q};
  assign dif.phase = ph_hi_q[PH_LSB +: 6];
  assign dif.sync = sync_ev;
  assign dif.ce = ce;

  ocd_chan_div u_div (
    .clk(clk),
    .rst(rst),
    .dif(dif)
  );

  ocd_pin_drv u_drv (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .mode(mode_q[3:0]),
    .src(dif.out_true),
    .plus_o(out_plus),
    .plus_oe(out_plus_oe),
    .minus_o(out_minus),
    .minus_oe(out_minus_oe)
  );

  // ----------------------------------------------------------------
  // Cleanup-loop output
  // ----------------------------------------------------------------

  always_comb begin
    case (clo_q[CLDIV_LSB +: 4])
      CLD_BY1: cl_d = 1'b1;
      CLD_BY2: cl_d = cl_cnt_q[0];
      CLD_BY4: cl_d = cl_cnt_q[1];
      CLD_BY8: cl_d = cl_cnt_q[2];
      CLD_BY16: cl_d = cl_cnt_q[3];
      default: cl_d = cl_cnt_q[0];
    endcase
  end

  // Free running prescaler and registered side outputs
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cl_cnt_q <= 4'h0;
      cleanup_loop_clock_output <= 1'b0;
      cleanup_loop_weak_drive <= 1'b0;
      channel_source_select <= 3'h0;
      half_step <= 1'b0;
    end else if (ce) begin
      cl_cnt_q <= cl_cnt_q + 4'h1;
      cleanup_loop_clock_output <= cl_d;
      cleanup_loop_weak_drive <= clo_q[WEAK_BIT];
      channel_source_select <= clo_q[SRC_LSB +: 3];
      half_step <= dif.half_step;
    end
  end
endmodule

// ==== inc/ocd_div_if.sv ====
`timescale 1ns/1ps
// Channel divider control and status between top and divider
interface ocd_div_if;
  logic ce;
  logic sync;
  logic [9:0] div_val;
  logic [5:0] phase;
  logic out_true;
  logic half_step;
  logic running;
  modport ctl (
    output ce,
    output sync,
    output div_val,
    output phase,
    input out_true,
    input half_step,
    input running
  );
  modport div (
    input ce,
    input sync,
    input div_val,
    input phase,
    output out_true,
    output half_step,
    output running
  );
endinterface

// ==== inc/ocd_pkg.sv ====
package ocd_pkg;

  // ----------------------------------------------------------------
  // Register indices and APB byte addresses (index times four)
  // ----------------------------------------------------------------
  localparam int unsigned PADDR_W = 14;
  localparam logic [11:0] IDX_MODE = 12'h190;
  localparam logic [11:0] IDX_DIV_LO = 12'h191;
  localparam logic [11:0] IDX_PH_HI = 12'h192;
  localparam logic [11:0] IDX_CLO = 12'h1BA;
  localparam logic [11:0] IDX_STAT = 12'h1BC;
  localparam logic [13:0] ADDR_MODE = {IDX_MODE, 2'b00};
  localparam logic [13:0] ADDR_DIV_LO = {IDX_DIV_LO, 2'b00};
  localparam logic [13:0] ADDR_PH_HI = {IDX_PH_HI, 2'b00};
  localparam logic [13:0] ADDR_CLO = {IDX_CLO, 2'b00};
  localparam logic [13:0] ADDR_STAT = {IDX_STAT, 2'b00};

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned PH_LSB = 2;
  localparam int unsigned DIVHI_LSB = 0;
  localparam int unsigned SRC_LSB = 5;
  localparam int unsigned WEAK_BIT = 4;
  localparam int unsigned CLDIV_LSB = 0;

  // ----------------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_MODE = 8'h0F;
  localparam logic [7:0] RST_DIV_LO = 8'h00;
  localparam logic [7:0] RST_PH_HI = 8'h00;
  localparam logic [7:0] RST_CLO = 8'h01;

  // ----------------------------------------------------------------
  // Driver mode codes
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    DRV_TRI0 = 4'h0,
    DRV_INPH_T = 4'h6,
    DRV_OPP_T = 4'h7,
    DRV_P_T = 4'h8,
    DRV_M_T = 4'h9,
    DRV_ZZ = 4'hA,
    DRV_INPH_C = 4'hB,
    DRV_OPP_C = 4'hC,
    DRV_P_C = 4'hD,
    DRV_M_C = 4'hE,
    DRV_TRI1 = 4'hF
  } ocd_drv_mode_t;

  // ----------------------------------------------------------------
  // Cleanup-loop output divider codes
  // ----------------------------------------------------------------
  localparam logic [3:0] CLD_BY1 = 4'h0;
  localparam logic [3:0] CLD_BY2 = 4'h1;
  localparam logic [3:0] CLD_BY4 = 4'h2;
  localparam logic [3:0] CLD_BY8 = 4'h4;
  localparam logic [3:0] CLD_BY16 = 4'h8;

endpackage

// ==== sim/ocd_checker.sv ====
`timescale 1ns/1ps
module ocd_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ocd_pkg::PADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic sync_n,
  input wire logic out_plus,
  input wire logic out_plus_oe,
  input wire logic out_minus,
  input wire logic out_minus_oe,
  input wire logic half_step,
  input wire logic cleanup_loop_weak_drive,
  input wire logic [2:0] channel_source_select
);
  import ocd_pkg::*;
  logic [7:0] mode_q, clo_q;
  logic [1:0] quiet_q;
  logic [2:0] sage_q;
  logic wr, ok;
  logic [3:0] m;
  assign wr = psel && penable && pready && pwrite && ce;
  assign ok = quiet_q == 2'h3;
  assign m = mode_q[3:0];
  // Shadow of the last written settings
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_q <= RST_MODE;
      clo_q <= RST_CLO;
    end else if (wr && paddr == ADDR_MODE) begin
      mode_q <= pwdata[7:0];
    end else if (wr && paddr == ADDR_CLO) begin
      clo_q <= pwdata[7:0];
    end
  end
  // Cycles since the last write, saturating
  always_ff @(posedge clk or posedge rst) begin
    if (rst) quiet_q <= 2'h3;
    else if (wr) quiet_q <= 2'h0;
    else if (!ok) quiet_q <= quiet_q + 2'h1;
  end
  // Cycles since the sync pin was low, saturating
  always_ff @(posedge clk or posedge rst) begin
    if (rst) sage_q <= 3'h7;
    else if (!sync_n) sage_q <= 3'h0;
    else if (sage_q != 3'h7) sage_q <= sage_q + 3'h1;
  end
  // --------
  // Checks
  // --------
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  opp_true_a:
    assert property (ok && m == 4'h7 |-> out_plus_oe && out_minus_oe
      && out_plus != out_minus) else $error("mode 7 pins wrong");
  inph_comp_a:
    assert property (ok && m == 4'hB |-> out_plus_oe && out_minus_oe
      && out_plus == out_minus) else $error("mode B pins wrong");
  opp_comp_a:
    assert property (ok && m == 4'hC |-> out_plus_oe && out_minus_oe
      && out_plus != out_minus) else $error("mode C pins wrong");
  pins_off_a:
    assert property (ok && (m == 4'hA || m == 4'hF) |-> !out_plus_oe
      && !out_minus_oe) else $error("pins not released");
  apb_answer_a:
    assert property (psel && !penable && ce |=> pready ##1 !pready)
      else $error("bus answer wrong");
  src_sel_a:
    assert property (ok |-> channel_source_select == clo_q[7:5])
      else $error("source select wrong");
  weak_drive_a:
    assert property (ok |-> cleanup_loop_weak_drive == clo_q[4])
      else $error("drive strength wrong");
  phase_hold_a:
    assert property ($changed(half_step) |-> sage_q < 3'h6)
      else $error("phase changed without sync");
endmodule

bind ocd_top ocd_checker i_chk (.clk, .rst, .ce, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pready, .sync_n, .out_plus, .out_plus_oe,
  .out_minus, .out_minus_oe, .half_step, .cleanup_loop_weak_drive,
  .channel_source_select);

// ==== sim/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
  import ocd_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic sync_n = 1'b1;
  logic [13:0] paddr = 14'h0000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata, rd;
  logic pready, pslverr, er, op, ope, om, ome, hs, clo, wk;
  logic [2:0] sel;
  int errors = 0;
  int checks_done = 0;
  int cyc = 0;
  int p, q;
  logic [13:0] ra [4] = '{ADDR_MODE, ADDR_DIV_LO, ADDR_PH_HI, ADDR_CLO};
  logic [7:0] rv [4] = '{8'h0F, 8'h00, 8'h00, 8'h01};
  logic [7:0] mt [12] = '{8'h7E, 8'hBA, 8'hCB, 8'h6F, 8'h8C, 8'h93,
    8'hD8, 8'hE2, 8'hA0, 8'hF0, 8'h00, 8'h30};
  logic [15:0] ct [5] = '{16'h2102, 16'h5204, 16'h8408, 16'hF810,
    16'h3000};
  logic [9:0] dv [3] = '{10'h001, 10'h005, 10'h102};
  logic [5:0] ph [2] = '{6'h3F, 6'h02};

  ocd_top i_dut (.clk, .rst, .ce, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .sync_n,
    .out_plus(op), .out_plus_oe(ope), .out_minus(om),
    .out_minus_oe(ome), .half_step(hs), .cleanup_loop_clock_output(clo),
    .cleanup_loop_weak_drive(wk), .channel_source_select(sel));

  // Clock and hang limit
  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      errors++;
      test_done();
    end
  end

  // --------
  // Tasks
  // --------
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      errors++;
      $display("unexpected at %0t: got %h exp %h", $time, s, e);
    end
  endtask

  // One bus transfer, then an idle edge
  task automatic apb(input logic w, input logic [13:0] a,
    input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  // Sync pulse, then settle
  task automatic sync;
    sync_n <= 1'b0;
    repeat (2) @(posedge clk);
    sync_n <= 1'b1;
    repeat (10) @(posedge clk);
  endtask

  // Period between rises of a pin, 0 if it never rises twice
  task automatic per(input logic s, output int r);
    int t;
    logic l, c;
    t = -1;
    r = 0;
    l = 1'b1;
    for (int k = 0; k < 800; k++) begin
      @(posedge clk);
      c = s ? clo : op;
      if (c === 1'b1 && l === 1'b0) begin
        if (t >= 0 && r == 0) r = k - t;
        t = k;
      end
      l = c;
    end
  endtask

  task automatic test_done;
    if (errors == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    foreach (ra[i]) begin
      apb(1'b0, ra[i], 32'h0);
      chk(rd, rv[i]);
    end
    foreach (mt[i]) begin
      apb(1'b1, ADDR_MODE, {28'h0, mt[i][7:4]});
      repeat (4) @(posedge clk);
      chk({ope, op & ope, ome, om & ome}, mt[i][3:0]);
      apb(1'b0, ADDR_MODE, 32'h0);
      chk(rd, mt[i][7:4]);
    end
    foreach (ct[i]) begin
      apb(1'b1, ADDR_CLO, {24'h0, ct[i][15:8]});
      per(1'b1, p);
      chk(p, ct[i][7:0]);
      chk({wk, sel}, {ct[i][12], ct[i][15:13]});
    end
    apb(1'b1, ADDR_MODE, 32'h8);
    q = 0;
    foreach (dv[i]) begin
      apb(1'b1, ADDR_DIV_LO, {24'h0, dv[i][7:0]});
      apb(1'b1, ADDR_PH_HI, {30'h0, dv[i][9:8]});
      per(1'b0, p);
      chk(p, q);
      sync();
      per(1'b0, p);
      q = dv[i] + 1;
      chk(p, q);
    end
    apb(1'b1, ADDR_DIV_LO, 32'h0);
    apb(1'b1, ADDR_PH_HI, 32'h0);
    sync();
    foreach (ph[i]) begin
      apb(1'b1, ADDR_PH_HI, {24'h0, ph[i], 2'b00});
      sync_n <= 1'b0;
      p = 0;
      repeat (60) begin
        @(posedge clk);
        sync_n <= 1'b1;
        if (op === 1'b0) p++;
      end
      // Sync edge itself holds the output low one more cycle
      chk(p, ph[i][5:1] + 6'h01);
      chk(hs, ph[i][0]);
    end
    apb(1'b1, 14'h0004, 32'hFF);
    apb(1'b0, 14'h0004, 32'h0);
    chk(rd, 32'h0);
    chk(er, 1'b1);
    // Clock enable low freezes the prescaler output
    apb(1'b1, ADDR_CLO, 32'h01);
    ce <= 1'b0;
    @(posedge clk);
    rd = {31'h0, clo};
    repeat (5) @(posedge clk);
    chk(clo, rd);
    ce <= 1'b1;
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, ADDR_MODE, 32'h0);
    chk(rd, 32'h0F);
    // Status after reset: divider by one, running, output high
    apb(1'b0, ADDR_STAT, 32'h0);
    chk(rd, 32'h03);
    test_done();
  end
endmodule
